// ==== shared/sld_pkg.sv ====
package sld_pkg;

  // Register addresses
  localparam logic [11:0] A_SYNC_CTRL = 12'h03A;
  localparam logic [11:0] A_SYNC_STAT = 12'h03B;
  localparam logic [11:0] A_CLK_PWR   = 12'h080;
  localparam logic [11:0] A_LANE_OFF  = 12'h201;
  localparam logic [11:0] A_RECOVERY  = 12'h230;
  localparam logic [11:0] A_LINK_CTRL = 12'h300;
  localparam logic [11:0] A_SUBCLASS  = 12'h301;
  localparam logic [11:0] A_FIX_DLY   = 12'h304;
  localparam logic [11:0] A_VAR_DLY   = 12'h306;
  localparam logic [11:0] A_LINK_SEL  = 12'h310;
  localparam logic [11:0] A_LINK_MODE = 12'h311;
  localparam logic [11:0] A_LINK_RES  = 12'h312;
  localparam logic [11:0] A_ROUTE     = 12'h313;
  localparam logic [11:0] A_STATUS    = 12'h3F0;
  localparam logic [11:0] A_CFG_LO    = 12'h450;
  localparam logic [11:0] A_CFG_HI    = 12'h45A;

  // Field positions
  localparam int CTRL_CKM_BIT   = 6;
  localparam int CTRL_DUAL_BIT  = 3;
  localparam int MODE_K32_BIT   = 4;
  localparam int MODE_SCR_BIT   = 5;
  localparam int MODE_HD_BIT    = 6;
  localparam int CLKPWR_LSB     = 6;
  localparam int REC_EQ_BIT     = 2;
  localparam int SYNC_LOCK_BIT  = 3;
  localparam int ST_CKERR0_BIT  = 0;
  localparam int ST_CKERR1_BIT  = 1;
  localparam int ST_CFGERR_BIT  = 2;
  localparam int ST_DLYERR_BIT  = 3;

  // Reset values and fixed codes
  localparam logic [7:0] LINK_MODE_RST = 8'h50;
  localparam logic [7:0] LINK_RES_REQ  = 8'hFF;
  localparam logic [7:0] JESD_VERSION  = 8'h01;
  localparam logic [1:0] PAIR_B_OFF    = 2'h1;
  localparam logic [7:0] SYNC_ONESHOT  = 8'h01;
  localparam logic [7:0] SYNC_ENABLE   = 8'h81;
  localparam logic [7:0] SYNC_ARM      = 8'hC1;
  localparam logic [7:0] VAR_DLY_MAX   = 8'h0A;

  // Clock-recovery rate ranges
  localparam logic [1:0] REC_OVERSAMPLE = 2'h0;
  localparam logic [1:0] REC_FULL       = 2'h1;
  localparam logic [1:0] REC_HALF       = 2'h2;

  typedef enum logic [2:0] {
    SY_IDLE    = 3'h0,
    SY_ONESHOT = 3'h1,
    SY_ENABLED = 3'h3,
    SY_ARMED   = 3'h2,
    SY_LOCKED  = 3'h6
  } sld_sync_t;

endpackage : sld_pkg

// ==== rtl/sld_mode_decode.sv ====
module sld_mode_decode (
  // Mode selection
  input  wire logic [3:0] mode,
  input  wire logic       k32,
  // Decoded parameters
  output logic       [2:0] conv_cnt,
  output logic       [3:0] lane_cnt,
  output logic       [1:0] samp_cnt,
  output logic       [2:0] octet_cnt,
  output logic             mode_ok,
  output logic             single_only,
  output logic             k_ok,
  output logic             hd_req,
  output logic       [5:0] cyc_per_mf,
  output logic       [7:0] lane_mask
);
  logic [1:0] shift;
  logic [5:0] kval;

  always_comb begin
    mode_ok     = 1'b1;
    single_only = (mode <= 4'h3);
    unique case (mode)
      4'h0:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h4, 4'h8, 2'h1, 3'h1};
      4'h1:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h4, 4'h8, 2'h2, 3'h2};
      4'h2:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h4, 4'h4, 2'h1, 3'h2};
      4'h3:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h4, 4'h2, 2'h1, 3'h4};
      4'h4:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h2, 4'h4, 2'h1, 3'h1};
      4'h5:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h2, 4'h4, 2'h2, 3'h2};
      4'h6:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h2, 4'h2, 2'h1, 3'h2};
      4'h7:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h2, 4'h1, 2'h1, 3'h4};
      4'h9:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h1, 4'h2, 2'h1, 3'h1};
      4'hA:    {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h1, 4'h1, 2'h1, 3'h2};
      default: begin
        {conv_cnt, lane_cnt, samp_cnt, octet_cnt} = {3'h4, 4'h8, 2'h1, 3'h1};
        mode_ok = 1'b0;
      end
    endcase
    k_ok   = k32 || !(mode == 4'h0 || mode == 4'h4 || mode == 4'h9);
    hd_req = (octet_cnt == 3'h1);
    // Frames per processing cycle is 4/F; shift by its log2
    shift  = (octet_cnt == 3'h1) ? 2'h2 : (octet_cnt == 3'h2) ? 2'h1 : 2'h0;
    kval   = k32 ? 6'h20 : 6'h10;
    cyc_per_mf = kval >> shift;
    lane_mask  = 8'((9'h001 << lane_cnt) - 9'h001);
  end

endmodule : sld_mode_decode

// ==== rtl/sld_mf_counter.sv ====
module sld_mf_counter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Processing-cycle tick and alignment
  input  wire logic       tick,
  input  wire logic       realign,
  input  wire logic [5:0] period,
  input  wire logic [4:0] offset,
  // Multiframe position
  output logic            boundary,
  output logic      [5:0] count
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       bnd;
  } sld_mfc_t;

  sld_mfc_t s_q;
  sld_mfc_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.bnd = 1'b0;
    if (realign) begin
      s_d.cnt = 6'(offset);
    end else if (tick) begin
      if (s_q.cnt >= period - 6'h01) begin
        s_d.cnt = 6'h00;
        s_d.bnd = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign boundary = s_q.bnd;
  assign count    = s_q.cnt;

endmodule : sld_mf_counter

// ==== rtl/sld_setup.sv ====
// Notes on behaviour
// - Modes 0-3 single link only, four converters, lanes 8/8/4/2, S 1/2/1/1, F 1/2/2/4.
// - Modes 4,5,6,7,9,10 single or dual; M, L, F per the mode table.
// - High density must be 1 when F is 1, else 0.
// - Resolution and bits per sample must both be 16.
// - K must be 32 in modes 0, 4, 9; others accept 16 or 32.
// - Dual link runs two separately resettable links with identical parameters.
// - Scrambling flag set means the receiver descrambles lane data.
// - Link target 0 or 1 steers following per-link configuration writes.
// - Lane enable and deskew mask is two to the L minus one.
// - A one in the lane power-off register powers down that physical lane.
// - Checksum method must match transmitter: 0 sums fields, 1 sums registers.
// - Field checksum is low byte of L,M,K,N,Np,S minus one plus flags.
// - Register checksum is low byte of sum of registers 0x450 to 0x45A.
// - Converter power-down mask from M and dual link: 0111, 0110, 0011, else 0.
// - Dual link with M of 1 routes second pair data to converter 3.
// - Second pair clock gated off when clock power bits 7:6 read 1.
// - Recovery settings: oversample 0/1/2, full rate 0/0/1, half rate 1/0/0.
// - Subclass 1 aligns to an external system reference edge.
// - Subclass 0 uses no reference and aligns to an internal clock.
// - Internal delays count processing cycles, one fortieth of lane rate.
// - Frames per processing cycle is 4/F; cycles per multiframe is K over that.
// - Variable delay may not exceed 10 processing cycles.
// - Sync control written 0x01, 0x81, 0xC1 in order selects, enables, arms.
module sld_setup (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // Link timing and checksum inputs
  input  wire logic        PCLK_TICK,
  input  wire logic        SYSREF,
  input  wire logic        CHK_VALID,
  input  wire logic        CHK_LINK,
  input  wire logic [7:0]  CHK_RX,
  // Lane and converter control
  output logic      [7:0]  LANE_ENABLE,
  output logic      [7:0]  LANE_PWR_OFF,
  output logic      [3:0]  CONV_PWR_DOWN,
  output logic             PAIR_B_CLK_OFF,
  output logic             ROUTE_TO_CH3,
  output logic      [1:0]  LINK_RUN,
  output logic      [1:0]  DESCRAMBLE,
  // Clock recovery
  output logic             REC_HALF_RATE,
  output logic             REC_OVERSAMPLE,
  output logic      [1:0]  REC_LOOP_DIV,
  output logic             EQ_LOW_POWER,
  // Alignment and status
  output logic             SYNC_LOCKED,
  output logic      [1:0]  MF_BOUNDARY,
  output logic             CHECKSUM_ERR,
  output logic             CONFIG_ERR
);

  typedef struct packed {
    logic [7:0]       clk_pwr;
    logic [7:0]       lane_off;
    logic [7:0]       recovery;
    logic [7:0]       link_ctrl;
    logic [7:0]       subclass;
    logic [7:0]       fix_dly;
    logic [7:0]       var_dly;
    logic             link_sel;
    logic [1:0][7:0]  link_mode;
    logic [1:0][7:0]  link_res;
    logic             route;
    logic [10:0][7:0] cfg;
    sld_pkg::sld_sync_t sync_st;
    logic [3:0]       status;
    logic [7:0]       rdata;
    logic [7:0]       lane_en;
    logic [3:0]       conv_pd;
    logic             pair_b_off;
    logic             route_out;
    logic [1:0]       link_run;
    logic [1:0]       descr;
    logic             half;
    logic             ovs;
    logic [1:0]       div;
    logic             eq;
  } sld_state_t;

  sld_state_t s_q;
  sld_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-link mode decode and multiframe counters

  logic [1:0][2:0] m_cnt;
  logic [1:0][3:0] l_cnt;
  logic [1:0][1:0] s_cnt;
  logic [1:0][2:0] f_cnt;
  logic [1:0]      mode_ok;
  logic [1:0]      single_only;
  logic [1:0]      k_ok;
  logic [1:0]      hd_req;
  logic [1:0][5:0] cyc_mf;
  logic [1:0][7:0] lmask;
  logic [1:0][7:0] exp_sum;
  logic [1:0]      link_bad;
  logic            realign;
  logic            dual;

  assign dual = s_q.link_ctrl[sld_pkg::CTRL_DUAL_BIT];

  for (genvar i = 0; i < 2; i++) begin : g_link
    sld_mode_decode u_dec (
      .mode        (s_q.link_mode[i][3:0]),
      .k32         (s_q.link_mode[i][sld_pkg::MODE_K32_BIT]),
      .conv_cnt    (m_cnt[i]),
      .lane_cnt    (l_cnt[i]),
      .samp_cnt    (s_cnt[i]),
      .octet_cnt   (f_cnt[i]),
      .mode_ok     (mode_ok[i]),
      .single_only (single_only[i]),
      .k_ok        (k_ok[i]),
      .hd_req      (hd_req[i]),
      .cyc_per_mf  (cyc_mf[i]),
      .lane_mask   (lmask[i])
    );

    sld_mf_counter u_mfc (
      .clk      (CLOCK),
      .rst_n    (RST_N),
      .tick     (PCLK_TICK),
      .realign  (realign),
      .period   (cyc_mf[i]),
      .offset   (s_q.fix_dly[4:0]),
      .boundary (MF_BOUNDARY[i]),
      .count    ()
    );

    // Field checksum over the configured link parameters
    always_comb begin
      logic [7:0] kk;
      kk = s_q.link_mode[i][sld_pkg::MODE_K32_BIT] ? 8'h1F : 8'h0F;
      exp_sum[i] = 8'(l_cnt[i] - 4'h1) + 8'(m_cnt[i] - 3'h1) + kk
                 + 8'(s_q.link_res[i][3:0]) + 8'(s_q.link_res[i][7:4])
                 + 8'(s_cnt[i] - 2'h1) + 8'(s_q.link_mode[i][sld_pkg::MODE_SCR_BIT])
                 + 8'(s_q.link_mode[i][sld_pkg::MODE_HD_BIT])
                 + 8'(s_q.subclass[0]) + sld_pkg::JESD_VERSION;
    end

    assign link_bad[i] = !mode_ok[i] || !k_ok[i]
                       || (dual && single_only[i])
                       || (s_q.link_mode[i][sld_pkg::MODE_HD_BIT] != hd_req[i])
                       || (s_q.link_res[i] != sld_pkg::LINK_RES_REQ);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Derived checks

  logic [7:0] reg_sum;
  logic [7:0] expected;
  logic       cfg_bad;
  logic       ck_miss;
  logic       wr_hit;

  always_comb begin
    reg_sum = 8'h00;
    for (int j = 0; j < 11; j++) begin
      reg_sum = reg_sum + s_q.cfg[j];
    end
  end

  assign expected = s_q.link_ctrl[sld_pkg::CTRL_CKM_BIT] ? reg_sum
                                                          : exp_sum[CHK_LINK];
  assign ck_miss  = CHK_VALID && (CHK_RX != expected);
  assign cfg_bad  = link_bad[0] || (dual && (link_bad[1]
                  || s_q.link_mode[0] != s_q.link_mode[1]
                  || s_q.link_res[0] != s_q.link_res[1]));
  assign wr_hit   = REG_WR;

  // Subclass 1 waits for the reference edge, subclass 0 for an internal tick
  assign realign = (s_q.sync_st == sld_pkg::SY_ARMED)
                 && (s_q.subclass[0] ? SYSREF : PCLK_TICK);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [3:0] clr;
    logic [3:0] set;
    s_d = s_q;
    clr = 4'h0;
    set = 4'h0;
    // Register writes
    if (wr_hit) begin
      unique case (REG_ADDR)
        sld_pkg::A_CLK_PWR:   s_d.clk_pwr  = REG_WDATA;
        sld_pkg::A_LANE_OFF:  s_d.lane_off = REG_WDATA;
        sld_pkg::A_RECOVERY:  s_d.recovery = REG_WDATA;
        sld_pkg::A_LINK_CTRL: s_d.link_ctrl = REG_WDATA;
        sld_pkg::A_SUBCLASS:  s_d.subclass = {7'h00, REG_WDATA[0]};
        sld_pkg::A_FIX_DLY:   s_d.fix_dly  = {3'h0, REG_WDATA[4:0]};
        sld_pkg::A_VAR_DLY: begin
          if (REG_WDATA > sld_pkg::VAR_DLY_MAX) begin
            s_d.var_dly = sld_pkg::VAR_DLY_MAX;
            set[sld_pkg::ST_DLYERR_BIT] = 1'b1;
          end else begin
            s_d.var_dly = REG_WDATA;
          end
        end
        sld_pkg::A_LINK_SEL:  s_d.link_sel = REG_WDATA[0];
        sld_pkg::A_LINK_MODE: s_d.link_mode[s_q.link_sel] = REG_WDATA;
        sld_pkg::A_LINK_RES:  s_d.link_res[s_q.link_sel]  = REG_WDATA;
        sld_pkg::A_ROUTE:     s_d.route    = REG_WDATA[0];
        sld_pkg::A_STATUS:    clr          = REG_WDATA[3:0];
        sld_pkg::A_SYNC_CTRL: begin
          if (REG_WDATA == sld_pkg::SYNC_ONESHOT) begin
            s_d.sync_st = sld_pkg::SY_ONESHOT;
          end else if (REG_WDATA == sld_pkg::SYNC_ENABLE
                       && s_q.sync_st == sld_pkg::SY_ONESHOT) begin
            s_d.sync_st = sld_pkg::SY_ENABLED;
          end else if (REG_WDATA == sld_pkg::SYNC_ARM
                       && s_q.sync_st == sld_pkg::SY_ENABLED) begin
            s_d.sync_st = sld_pkg::SY_ARMED;
          end else begin
            s_d.sync_st = sld_pkg::SY_IDLE;
          end
        end
        default: begin
          if (REG_ADDR >= sld_pkg::A_CFG_LO && REG_ADDR <= sld_pkg::A_CFG_HI) begin
            s_d.cfg[4'(REG_ADDR - sld_pkg::A_CFG_LO)] = REG_WDATA;
          end
        end
      endcase
    end
    if (realign) begin
      s_d.sync_st = sld_pkg::SY_LOCKED;
    end
    // Sticky status: a new event wins over a clear in the same cycle
    set[sld_pkg::ST_CKERR0_BIT] = ck_miss && !CHK_LINK;
    set[sld_pkg::ST_CKERR1_BIT] = ck_miss && CHK_LINK;
    set[sld_pkg::ST_CFGERR_BIT] = cfg_bad;
    s_d.status = (s_q.status & ~clr) | set;
    // Read data
    s_d.rdata = s_q.rdata;
    if (REG_RD) begin
      unique case (REG_ADDR)
        sld_pkg::A_CLK_PWR:   s_d.rdata = s_q.clk_pwr;
        sld_pkg::A_LANE_OFF:  s_d.rdata = s_q.lane_off;
        sld_pkg::A_RECOVERY:  s_d.rdata = s_q.recovery;
        sld_pkg::A_LINK_CTRL: s_d.rdata = s_q.link_ctrl;
        sld_pkg::A_SUBCLASS:  s_d.rdata = s_q.subclass;
        sld_pkg::A_FIX_DLY:   s_d.rdata = s_q.fix_dly;
        sld_pkg::A_VAR_DLY:   s_d.rdata = s_q.var_dly;
        sld_pkg::A_LINK_SEL:  s_d.rdata = {7'h00, s_q.link_sel};
        sld_pkg::A_LINK_MODE: s_d.rdata = s_q.link_mode[s_q.link_sel];
        sld_pkg::A_LINK_RES:  s_d.rdata = s_q.link_res[s_q.link_sel];
        sld_pkg::A_ROUTE:     s_d.rdata = {7'h00, s_q.route};
        sld_pkg::A_STATUS:    s_d.rdata = {4'h0, s_q.status};
        sld_pkg::A_SYNC_STAT: begin
          s_d.rdata = 8'h00;
          s_d.rdata[sld_pkg::SYNC_LOCK_BIT] = (s_q.sync_st == sld_pkg::SY_LOCKED);
        end
        default: begin
          if (REG_ADDR >= sld_pkg::A_CFG_LO && REG_ADDR <= sld_pkg::A_CFG_HI) begin
            s_d.rdata = s_q.cfg[4'(REG_ADDR - sld_pkg::A_CFG_LO)];
          end else begin
            s_d.rdata = 8'h00;
          end
        end
      endcase
    end
    // Registered control outputs
    s_d.lane_en = dual ? {lmask[1][3:0], lmask[0][3:0]} : lmask[0];
    unique case ({m_cnt[0], dual})
      {3'h1, 1'b0}: s_d.conv_pd = 4'b0111;
      {3'h1, 1'b1}: s_d.conv_pd = 4'b0110;
      {3'h2, 1'b0}: s_d.conv_pd = 4'b0011;
      default:      s_d.conv_pd = 4'b0000;
    endcase
    s_d.pair_b_off = (s_q.clk_pwr[sld_pkg::CLKPWR_LSB +: 2] == sld_pkg::PAIR_B_OFF);
    s_d.route_out  = s_q.route && dual && (m_cnt[0] == 3'h1);
    s_d.link_run   = {s_q.link_ctrl[1] && dual, s_q.link_ctrl[0]};
    s_d.descr      = {s_q.link_mode[dual][sld_pkg::MODE_SCR_BIT] && s_d.link_run[1],
                      s_q.link_mode[0][sld_pkg::MODE_SCR_BIT]};
    unique case (s_q.recovery[1:0])
      sld_pkg::REC_FULL: {s_d.half, s_d.ovs, s_d.div} = {1'b0, 1'b0, 2'h1};
      sld_pkg::REC_HALF: {s_d.half, s_d.ovs, s_d.div} = {1'b1, 1'b0, 2'h0};
      default:           {s_d.half, s_d.ovs, s_d.div} = {1'b0, 1'b1, 2'h2};
    endcase
    s_d.eq = s_q.recovery[sld_pkg::REC_EQ_BIT];
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q           <= '0;
      s_q.link_mode <= {2{sld_pkg::LINK_MODE_RST}};
      s_q.link_res  <= {2{sld_pkg::LINK_RES_REQ}};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign REG_RDATA      = s_q.rdata;
  assign LANE_ENABLE    = s_q.lane_en;
  assign LANE_PWR_OFF   = s_q.lane_off;
  assign CONV_PWR_DOWN  = s_q.conv_pd;
  assign PAIR_B_CLK_OFF = s_q.pair_b_off;
  assign ROUTE_TO_CH3   = s_q.route_out;
  assign LINK_RUN       = s_q.link_run;
  assign DESCRAMBLE     = s_q.descr;
  assign REC_HALF_RATE  = s_q.half;
  assign REC_OVERSAMPLE = s_q.ovs;
  assign REC_LOOP_DIV   = s_q.div;
  assign EQ_LOW_POWER   = s_q.eq;
  assign SYNC_LOCKED    = (s_q.sync_st == sld_pkg::SY_LOCKED);
  assign CHECKSUM_ERR   = |s_q.status[1:0];
  assign CONFIG_ERR     = s_q.status[sld_pkg::ST_CFGERR_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  dual_mode_a: assert property (dual && s_q.link_mode[0][3:0] <= 4'h3 |=> CONFIG_ERR)
    else $error("single-link mode in dual link not flagged");
  lane_mask_a: assert property (!dual ##1 !dual |-> LANE_ENABLE == $past(lmask[0]))
    else $error("lane mask does not follow lane count");
  lane_off_a: assert property (REG_WR && REG_ADDR == sld_pkg::A_LANE_OFF |=>
                               LANE_PWR_OFF == $past(REG_WDATA))
    else $error("lane power-off not taken");
  conv_pd_a: assert property (m_cnt[0] == 3'h1 && !dual |=> CONV_PWR_DOWN == 4'b0111)
    else $error("converter power mask wrong");
  pair_clk_a: assert property (PAIR_B_CLK_OFF |-> $past(s_q.clk_pwr[7:6]) == 2'h1)
    else $error("pair clock gated without field set");
  var_dly_a: assert property (s_q.var_dly <= 8'h0A)
    else $error("variable delay above ten");
  chk_err_a: assert property (ck_miss |=> CHECKSUM_ERR ##1 CHECKSUM_ERR || $past(REG_WR))
    else $error("checksum mismatch not flagged");
  sync_seq_a: assert property (REG_WR && REG_ADDR == sld_pkg::A_SYNC_CTRL
                               && REG_WDATA == sld_pkg::SYNC_ARM
                               && s_q.sync_st != sld_pkg::SY_ENABLED |=> !SYNC_LOCKED)
    else $error("arm accepted out of order");
  lock_ref_a: assert property ($rose(SYNC_LOCKED) |-> $past(s_q.subclass[0] ? SYSREF
                                                              : PCLK_TICK))
    else $error("lock without alignment event");
  recovery_a: assert property (s_q.recovery[1:0] == sld_pkg::REC_HALF |=>
                               REC_HALF_RATE && !REC_OVERSAMPLE && REC_LOOP_DIV == 2'h0)
    else $error("half rate recovery settings wrong");
  link_one_a: assert property (!$past(dual) |-> !LINK_RUN[1])
    else $error("second link runs in single link");

  lock_c:    cover property (SYNC_LOCKED && s_q.subclass[0]);
  ckerr_c:   cover property (CHECKSUM_ERR);
  dual_run_c: cover property (LINK_RUN == 2'b11);

endmodule : sld_setup

// ==== bench/sld_partner.sv ====
module sld_partner (
  // Clock
  input  wire logic       clk,
  // Transmitter side
  output logic            pclk_tick,
  output logic            sysref,
  output logic            chk_valid,
  output logic            chk_link,
  output logic      [7:0] chk_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 0;
  initial begin
    {pclk_tick, sysref, chk_valid, chk_link, chk_rx} = '0;
  end
  // Processing-cycle tick, one clock in four
  always @(negedge clk) begin
    div <= (div + 1) % 4;
    pclk_tick <= (div == 0);
  end
  // Reference pulse, aligned to the clock
  task automatic send_ref();
    @(negedge clk) sysref <= 1'b1;
    @(negedge clk) sysref <= 1'b0;
  endtask : send_ref
  // One checksum report; the byte is inverted once released
  task automatic send_chk(input logic lnk, input logic [7:0] val);
    @(negedge clk) {chk_valid, chk_link, chk_rx} <= {1'b1, lnk, val};
    @(negedge clk) {chk_valid, chk_rx} <= {1'b0, ~val};
  endtask : send_chk
endmodule : sld_partner

// ==== bench/serial_link_deframer_setup_test.sv ====
module serial_link_deframer_setup_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic [7:0]  REG_WDATA = 8'h00, REG_RDATA, LANE_ENABLE, LANE_PWR_OFF, CHK_RX, v, pd;
  logic [3:0]  CONV_PWR_DOWN;
  logic [1:0]  LINK_RUN, DESCRAMBLE, REC_LOOP_DIV, MF_BOUNDARY;
  logic        PAIR_B_CLK_OFF, ROUTE_TO_CH3, REC_HALF_RATE, REC_OVERSAMPLE, EQ_LOW_POWER;
  logic        SYNC_LOCKED, CHECKSUM_ERR, CONFIG_ERR, PCLK_TICK, SYSREF, CHK_VALID, CHK_LINK;
  logic [3:0]  rec[3] = '{4'h6, 4'h1, 4'h8};
  int          l_of[11] = '{8, 8, 4, 2, 4, 4, 2, 1, 0, 2, 1};
  int          m_of[11] = '{4, 4, 4, 4, 2, 2, 2, 2, 0, 1, 1};
  int          s_of[11] = '{1, 2, 1, 1, 1, 2, 1, 1, 0, 1, 1};
  int          f_of[11] = '{1, 2, 2, 4, 1, 2, 2, 4, 0, 1, 2};
  int          errors = 0, checks = 0, cyc = 0, sum;
  int          seed = 32'h868a948e;
  sld_setup i_dut (.CLOCK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .PCLK_TICK, .SYSREF, .CHK_VALID, .CHK_LINK, .CHK_RX, .LANE_ENABLE, .LANE_PWR_OFF,
    .CONV_PWR_DOWN, .PAIR_B_CLK_OFF, .ROUTE_TO_CH3, .LINK_RUN, .DESCRAMBLE, .REC_HALF_RATE,
    .REC_OVERSAMPLE, .REC_LOOP_DIV, .EQ_LOW_POWER, .SYNC_LOCKED, .MF_BOUNDARY,
    .CHECKSUM_ERR, .CONFIG_ERR);
  sld_partner i_tx (.clk(CLOCK), .pclk_tick(PCLK_TICK), .sysref(SYSREF),
    .chk_valid(CHK_VALID), .chk_link(CHK_LINK), .chk_rx(CHK_RX));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge CLOCK);
    REG_WR = 1'b0;
  endtask : wr
  // Write, then let derived outputs settle
  task automatic wrs(input logic [11:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (2) @(negedge CLOCK);
  endtask : wrs
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge CLOCK);
    {REG_RD, REG_ADDR} = {1'b1, a};
    @(negedge CLOCK);
    REG_RD = 1'b0;
    chk(REG_RDATA, exp, "read");
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge CLOCK);
    RST_N = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(LANE_ENABLE, 8'hFF, "lanes");
    rd(sld_pkg::A_LINK_MODE, sld_pkg::LINK_MODE_RST);
    rd(12'h7FF, 8'h00);
    v = 8'($random(seed));
    wr(sld_pkg::A_LANE_OFF, v);
    rd(sld_pkg::A_LANE_OFF, v);
    chk(LANE_PWR_OFF, v, "lane off");
    for (int i = 0; i < 3; i++) begin
      wrs(sld_pkg::A_RECOVERY, {5'h0, i == 1, 2'(i)});
      chk({3'h0, EQ_LOW_POWER, REC_HALF_RATE, REC_OVERSAMPLE, REC_LOOP_DIV},
          {3'h0, i == 1, rec[i]}, "cdr");
    end
    wrs(sld_pkg::A_CLK_PWR, 8'h40);
    chk({7'h0, PAIR_B_CLK_OFF}, 8'h01, "clk off");
    $display("test registers done");
    wr(sld_pkg::A_SUBCLASS, 8'h01);
    wr(sld_pkg::A_SYNC_CTRL, sld_pkg::SYNC_ONESHOT);
    wr(sld_pkg::A_SYNC_CTRL, sld_pkg::SYNC_ENABLE);
    wr(sld_pkg::A_SYNC_CTRL, sld_pkg::SYNC_ARM);
    i_tx.send_ref();
    repeat (2) @(negedge CLOCK);
    chk({7'h0, SYNC_LOCKED}, 8'h01, "lock");
    rd(sld_pkg::A_SYNC_STAT, 8'h08);
    do @(negedge CLOCK); while (!MF_BOUNDARY[0]);
    sum = cyc;
    do @(negedge CLOCK); while (!MF_BOUNDARY[0]);
    // K over 4/F processing cycles, one tick every 4 clocks
    chk(8'(cyc - sum), 8'(32 / (4 / f_of[0]) * 4), "mf period");
    wr(sld_pkg::A_SUBCLASS, 8'h00);
    wr(sld_pkg::A_SYNC_CTRL, sld_pkg::SYNC_ONESHOT);
    chk({7'h0, SYNC_LOCKED}, 8'h00, "unlock");
    wr(sld_pkg::A_SYNC_CTRL, sld_pkg::SYNC_ENABLE);
    wr(sld_pkg::A_SYNC_CTRL, sld_pkg::SYNC_ARM);
    repeat (6) @(negedge CLOCK);
    chk({7'h0, SYNC_LOCKED}, 8'h01, "lock sc0");
    wr(sld_pkg::A_SUBCLASS, 8'h01);
    $display("test sync done");
    for (int md = 0; md < 11; md++) begin
      if (md == 8) continue;
      wrs(sld_pkg::A_LINK_MODE, {1'b0, 1'(f_of[md] == 1), 2'b01, 4'(md)});
      pd = (m_of[md] == 1) ? 8'h07 : (m_of[md] == 2) ? 8'h03 : 8'h00;
      chk(LANE_ENABLE, 8'((1 << l_of[md]) - 1), "lanes");
      chk({4'h0, CONV_PWR_DOWN}, pd, "pd");
      chk({7'h0, CONFIG_ERR}, 8'h00, "cfg");
      // L-1, M-1, S-1, K-1 = 31, N-1 = Np-1 = 15, HD, subclass 1, version 1
      sum = l_of[md] + m_of[md] + s_of[md] - 3 + 61 + int'(f_of[md] == 1) + 2;
      i_tx.send_chk(1'b0, 8'(sum));
      @(negedge CLOCK);
      chk({7'h0, CHECKSUM_ERR}, 8'h00, "sum");
    end
    wrs(sld_pkg::A_LINK_MODE, 8'h40);
    chk({7'h0, CONFIG_ERR}, 8'h01, "k16");
    wrs(sld_pkg::A_LINK_MODE, 8'h12);
    wrs(sld_pkg::A_STATUS, 8'h04);
    chk({7'h0, CONFIG_ERR}, 8'h00, "cfg clear");
    wrs(sld_pkg::A_LINK_MODE, 8'h52);
    chk({7'h0, CONFIG_ERR}, 8'h01, "hd");
    wrs(sld_pkg::A_LINK_MODE, 8'h12);
    v = 8'($random(seed)) | 8'h01;
    i_tx.send_chk(1'b0, 8'h45 ^ v);
    @(negedge CLOCK);
    chk({7'h0, CHECKSUM_ERR}, 8'h01, "bad sum");
    wrs(sld_pkg::A_STATUS, 8'h01);
    chk({7'h0, CHECKSUM_ERR}, 8'h00, "clear");
    $display("test modes done");
    wr(sld_pkg::A_LINK_MODE, 8'h79);
    wr(sld_pkg::A_LINK_SEL, 8'h01);
    wr(sld_pkg::A_LINK_MODE, 8'h79);
    wr(sld_pkg::A_ROUTE, 8'h01);
    wr(sld_pkg::A_LINK_CTRL, 8'h0B);
    wrs(sld_pkg::A_STATUS, 8'h0F);
    chk(LANE_ENABLE, {2{4'((1 << l_of[9]) - 1)}}, "dual lanes");
    chk({4'h0, CONV_PWR_DOWN}, 8'h06, "dual pd");
    chk({5'h0, ROUTE_TO_CH3, LINK_RUN}, 8'h07, "route run");
    chk({6'h0, DESCRAMBLE}, 8'h03, "descramble");
    chk({7'h0, CONFIG_ERR}, 8'h00, "dual cfg");
    wr(sld_pkg::A_LINK_SEL, 8'h00);
    wrs(sld_pkg::A_LINK_MODE, 8'h50);
    chk({7'h0, CONFIG_ERR}, 8'h01, "dual mode 0");
    $display("test dual done");
    v = 8'($random(seed));
    wr(sld_pkg::A_CFG_LO, v);
    wr(sld_pkg::A_CFG_HI, 8'h05);
    rd(sld_pkg::A_CFG_LO, v);
    wrs(sld_pkg::A_LINK_CTRL, 8'h41);
    wrs(sld_pkg::A_STATUS, 8'h0F);
    chk({6'h0, LINK_RUN}, 8'h01, "single run");
    i_tx.send_chk(1'b0, v + 8'h05);
    @(negedge CLOCK);
    chk({7'h0, CHECKSUM_ERR}, 8'h00, "reg sum");
    wr(sld_pkg::A_VAR_DLY, 8'h0B);
    rd(sld_pkg::A_VAR_DLY, sld_pkg::VAR_DLY_MAX);
    rd(sld_pkg::A_STATUS, 8'h08);
    $display("test delay done");
    end_of_test();
  end
endmodule : serial_link_deframer_setup_test
